/* src/gpcfg_pkg.sv */
// constants for the pin configuration and interrupt qualification block
package gpcfg_pkg;
    // register command bytes
    localparam logic [7:0] ADDR_LATCH_P1 = 8'h45;
    localparam logic [7:0] ADDR_PULL_EN_P0 = 8'h46;
    localparam logic [7:0] ADDR_PULL_EN_P1 = 8'h47;
    localparam logic [7:0] ADDR_PULL_SEL_P0 = 8'h48;
    localparam logic [7:0] ADDR_PULL_SEL_P1 = 8'h49;
    localparam logic [7:0] ADDR_MASK_P0 = 8'h4a;
    localparam logic [7:0] ADDR_MASK_P1 = 8'h4b;
    localparam logic [7:0] ADDR_SRC_P0 = 8'h4c;
    localparam logic [7:0] ADDR_SRC_P1 = 8'h4d;
    localparam logic [7:0] ADDR_OUT_STAGE = 8'h4f;
    // the two registers of a pair differ only in bit 0
    localparam logic [7:0] PAIR_FLIP = 8'h01;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // field positions in the output stage register
    localparam int OD_P0_BIT = 0;
    localparam int OD_P1_BIT = 1;
    localparam int OD_WIDTH = 2;
    // reset values
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [15:0] PULL_EN_RST = 16'h0000;
    localparam logic [15:0] PULL_SEL_RST = 16'hffff;
    localparam logic [15:0] MASK_RST = 16'hffff;
    localparam logic [1:0] OD_RST = 2'h0;
    localparam logic [7:0] RESERVED_ZERO = 8'h00;
    localparam int PINS = 16;
    localparam int PORT_W = 8;
endpackage

/* src/gpcfg_top.sv */
// pull, mask, status and output stage logic of a two-port pin expander
`timescale 1ns/1ns
`default_nettype none
module gpcfg_top
    import gpcfg_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic LINK_CLK_I,
    input wire logic LINK_CMD_VALID_I,
    input wire logic [7:0] LINK_CMD_I,
    input wire logic LINK_WR_VALID_I,
    input wire logic [7:0] LINK_WDATA_I,
    input wire logic LINK_RD_REQ_I,
    output logic LINK_READY_O,
    output logic [7:0] LINK_RDATA_O,
    output logic LINK_RD_VALID_O,
    input wire logic [gpcfg_pkg::PINS-1:0] PIN_IN_I,
    input wire logic [gpcfg_pkg::PINS-1:0] DIR_IN_I,
    input wire logic [gpcfg_pkg::PINS-1:0] OUT_VAL_I,
    input wire logic IN_RD_P0_I,
    input wire logic IN_RD_P1_I,
    output logic [gpcfg_pkg::PINS-1:0] IN_VALUE_O,
    output logic [gpcfg_pkg::PINS-1:0] PULL_EN_O,
    output logic [gpcfg_pkg::PINS-1:0] PULL_UP_O,
    output logic [gpcfg_pkg::PINS-1:0] PULL_DN_O,
    output logic [gpcfg_pkg::PINS-1:0] HS_DRV_EN_O,
    output logic [gpcfg_pkg::PINS-1:0] LS_DRV_EN_O,
    output logic INT_N_O,
    output logic INT_OE_O
);
    import gpcfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state of both domains

    typedef struct packed {
        logic [7:0] ptr;
        logic req_tgl;
        logic is_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic [7:0] rdata;
        logic rd_valid;
    } gpcfg_link_st_t;

    typedef struct packed {
        logic boot;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tgl;
        logic [7:0] rdata;
        logic [7:0] latch_p1;
        logic [PINS-1:0] pull_en;
        logic [PINS-1:0] pull_sel;
        logic [PINS-1:0] mask;
        logic [OD_WIDTH-1:0] od;
        logic [PINS-1:0] pin_s1;
        logic [PINS-1:0] pin_s2;
        logic [PINS-1:0] ref_v;
        logic [PINS-1:0] held;
        logic [PINS-1:0] cap;
    } gpcfg_core_st_t;

    gpcfg_link_st_t l_q;
    gpcfg_link_st_t l_d;
    gpcfg_core_st_t c_q;
    gpcfg_core_st_t c_d;

    ////////////////////////////////////////////////////////////////////////////
    // link side: command pointer and toggle handshake toward the core

    always_comb
    begin
        l_d = l_q;
        l_d.rd_valid = 1'b0;
        l_d.ack_s1 = c_q.ack_tgl;
        l_d.ack_s2 = l_q.ack_s1;
        if (l_q.busy && (l_q.ack_s2 == l_q.req_tgl))
        begin
            l_d.busy = 1'b0;
            if (!l_q.is_wr)
            begin
                // core read data is held still until the next request
                l_d.rdata = c_q.rdata;
                l_d.rd_valid = 1'b1;
            end
        end
        if (LINK_CMD_VALID_I)
        begin
            l_d.ptr = LINK_CMD_I;
        end
        else if ((LINK_WR_VALID_I || LINK_RD_REQ_I) && !l_q.busy)
        begin
            l_d.addr = l_q.ptr;
            l_d.is_wr = LINK_WR_VALID_I;
            l_d.wdata = LINK_WDATA_I;
            l_d.req_tgl = ~l_q.req_tgl;
            l_d.busy = 1'b1;
            l_d.ptr = l_q.ptr ^ PAIR_FLIP;
        end
    end

    always_ff @(posedge LINK_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    assign LINK_READY_O = ~l_q.busy;
    assign LINK_RDATA_O = l_q.rdata;
    assign LINK_RD_VALID_O = l_q.rd_valid;

    pair_ptr_a: assert property (@(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (!LINK_CMD_VALID_I && LINK_WR_VALID_I && !l_q.busy) |=> (l_q.ptr == ($past(l_q.ptr) ^ PAIR_FLIP)))
        else $error("pair pointer did not flip");

    pair_read_a: assert property (@(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (!LINK_CMD_VALID_I && LINK_RD_REQ_I && !l_q.busy) |=> (l_q.ptr == ($past(l_q.ptr) ^ PAIR_FLIP)))
        else $error("pair pointer did not flip after read");

    ////////////////////////////////////////////////////////////////////////////
    // core side: register file and pending interrupt tracking

    logic [PINS-1:0] latch_en;
    logic [PINS-1:0] chg;
    logic [PINS-1:0] clr;
    logic [PINS-1:0] pend;
    logic [PINS-1:0] src;
    logic [PINS-1:0] od_pin;
    logic [PINS-1:0] pull_eff;
    logic do_req;

    function automatic logic [7:0] rd_mux(input gpcfg_core_st_t s, input logic [7:0] a,
                                          input logic [PINS-1:0] sv);
        logic [7:0] r;
        r = UNMAPPED_READ;
        case (a)
            ADDR_LATCH_P1: r = s.latch_p1;
            ADDR_PULL_EN_P0: r = s.pull_en[PORT_W-1:0];
            ADDR_PULL_EN_P1: r = s.pull_en[PINS-1:PORT_W];
            ADDR_PULL_SEL_P0: r = s.pull_sel[PORT_W-1:0];
            ADDR_PULL_SEL_P1: r = s.pull_sel[PINS-1:PORT_W];
            ADDR_MASK_P0: r = s.mask[PORT_W-1:0];
            ADDR_MASK_P1: r = s.mask[PINS-1:PORT_W];
            ADDR_SRC_P0: r = sv[PORT_W-1:0];
            ADDR_SRC_P1: r = sv[PINS-1:PORT_W];
            ADDR_OUT_STAGE: r = {RESERVED_ZERO[7:OD_WIDTH], s.od};
            default: r = UNMAPPED_READ;
        endcase
        return r;
    endfunction

    // port 0 has no latch enable in this block, so its pins never latch
    assign latch_en = {c_q.latch_p1, 8'h00};
    assign chg = DIR_IN_I & (c_q.pin_s2 ^ c_q.ref_v);
    assign clr = {{PORT_W{IN_RD_P1_I}}, {PORT_W{IN_RD_P0_I}}};
    // a latched pin stays pending even if it returns to its old level
    assign pend = c_q.held | chg;
    assign src = pend & ~c_q.mask;
    assign do_req = (c_q.req_s2 != c_q.req_seen);

    always_comb
    begin
        c_d = c_q;
        c_d.boot = 1'b0;
        c_d.req_s1 = l_q.req_tgl;
        c_d.req_s2 = c_q.req_s1;
        c_d.pin_s1 = PIN_IN_I;
        c_d.pin_s2 = c_q.pin_s1;
        for (int i = 0; i < PINS; i++)
        begin
            if (clr[i])
            begin
                // reading the input port consumes the event
                c_d.ref_v[i] = c_q.pin_s2[i];
                c_d.held[i] = 1'b0;
            end
            else if (latch_en[i] && chg[i] && !c_q.held[i])
            begin
                c_d.held[i] = 1'b1;
                c_d.cap[i] = c_q.pin_s2[i];
            end
        end
        if (do_req)
        begin
            c_d.req_seen = c_q.req_s2;
            c_d.ack_tgl = c_q.req_s2;
            if (l_q.is_wr)
            begin
                case (l_q.addr)
                    ADDR_LATCH_P1: c_d.latch_p1 = l_q.wdata;
                    ADDR_PULL_EN_P0: c_d.pull_en[PORT_W-1:0] = l_q.wdata;
                    ADDR_PULL_EN_P1: c_d.pull_en[PINS-1:PORT_W] = l_q.wdata;
                    ADDR_PULL_SEL_P0: c_d.pull_sel[PORT_W-1:0] = l_q.wdata;
                    ADDR_PULL_SEL_P1: c_d.pull_sel[PINS-1:PORT_W] = l_q.wdata;
                    ADDR_MASK_P0: c_d.mask[PORT_W-1:0] = l_q.wdata;
                    ADDR_MASK_P1: c_d.mask[PINS-1:PORT_W] = l_q.wdata;
                    ADDR_OUT_STAGE: c_d.od = l_q.wdata[OD_WIDTH-1:0];
                    default: c_d.od = c_q.od;
                endcase
            end
            else
            begin
                c_d.rdata = rd_mux(c_q, l_q.addr, src);
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            c_q <= '0;
            c_q.boot <= 1'b1;
            c_q.latch_p1 <= LATCH_RST;
            c_q.pull_en <= PULL_EN_RST;
            c_q.pull_sel <= PULL_SEL_RST;
            c_q.mask <= MASK_RST;
            c_q.od <= OD_RST;
        end
        else
        begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers, pulls and interrupt line

    assign od_pin = {{PORT_W{c_q.od[OD_P1_BIT]}}, {PORT_W{c_q.od[OD_P0_BIT]}}};
    assign pull_eff = c_q.pull_en & ~od_pin;
    assign PULL_EN_O = pull_eff;
    assign PULL_UP_O = pull_eff & c_q.pull_sel;
    assign PULL_DN_O = pull_eff & ~c_q.pull_sel;
    assign HS_DRV_EN_O = ~DIR_IN_I & OUT_VAL_I & ~od_pin;
    assign LS_DRV_EN_O = ~DIR_IN_I & ~OUT_VAL_I;
    assign IN_VALUE_O = (latch_en & c_q.held & c_q.cap) | (~(latch_en & c_q.held) & c_q.pin_s2);
    // open-drain line: only ever pulls low
    assign INT_N_O = 1'b0;
    assign INT_OE_O = |src;

    mask_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        c_q.boot |-> (c_q.mask == MASK_RST && !INT_OE_O))
        else $error("mask not all ones after reset");

    masked_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (c_q.mask == MASK_RST) |-> !INT_OE_O)
        else $error("interrupt asserted while fully masked");

    unmask_fire_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (|(pend & $past(c_q.mask) & ~c_q.mask)) |-> INT_OE_O)
        else $error("unmasked pending change did not raise interrupt");

    remask_drop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (INT_OE_O && do_req && l_q.is_wr && l_q.addr == ADDR_MASK_P0 && l_q.wdata == 8'hff
         && src[PINS-1:PORT_W] == 8'h00) |=> (src[PORT_W-1:0] == 8'h00))
        else $error("masking a source did not drop it");

    status_mask_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (do_req && !l_q.is_wr && l_q.addr == ADDR_SRC_P1) |=> ((c_q.rdata & $past(c_q.mask[PINS-1:PORT_W])) == 8'h00))
        else $error("masked pin read as interrupt source");

    od_high_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((HS_DRV_EN_O & od_pin) == 16'h0000) && ((PULL_EN_O & od_pin) == 16'h0000))
        else $error("open-drain port has high driver or pull on");

    input_hiz_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((HS_DRV_EN_O | LS_DRV_EN_O) & DIR_IN_I) == 16'h0000)
        else $error("input pin has a driver enabled");

    latch_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (|(c_q.held & ~clr)) |=> (((c_q.held & $past(c_q.held & ~clr)) == $past(c_q.held & ~clr))
                                  && ((c_q.cap & $past(c_q.held & ~clr)) == $past(c_q.cap & c_q.held & ~clr))))
        else $error("latched value lost before input read");

    od_reserved_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (do_req && !l_q.is_wr && l_q.addr == ADDR_OUT_STAGE) |=> (c_q.rdata[7:OD_WIDTH] == 6'h00))
        else $error("reserved output stage bits read nonzero");

    // a rise needs a new pin level, a mask change or a pin turned into an input
    irq_cause_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(INT_OE_O) |-> ((c_q.pin_s2 != $past(c_q.pin_s2)) || (c_q.mask != $past(c_q.mask))
                             || (DIR_IN_I != $past(DIR_IN_I))))
        else $error("interrupt rose with no pin, mask or direction change");

    unmask_held_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (do_req && l_q.is_wr && l_q.addr == ADDR_MASK_P1 && !IN_RD_P1_I
         && (|(c_q.held[PINS-1:PORT_W] & ~l_q.wdata))) |=> INT_OE_O)
        else $error("latched pending change not raised when unmasked");

    sel_store_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (do_req && l_q.is_wr && l_q.addr == ADDR_PULL_SEL_P0)
        |=> (c_q.pull_sel[PORT_W-1:0] == $past(l_q.wdata)))
        else $error("pull select write not stored");

    od_store_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (do_req && l_q.is_wr && l_q.addr == ADDR_OUT_STAGE) |=> (c_q.od == $past(l_q.wdata[OD_WIDTH-1:0])))
        else $error("output stage write not stored");

    read_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        IN_RD_P1_I |=> (c_q.held[PINS-1:PORT_W] == 8'h00))
        else $error("input read left a latched event pending");

    drive_out_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((~DIR_IN_I & ~(HS_DRV_EN_O | LS_DRV_EN_O) & ~(OUT_VAL_I & od_pin)) == 16'h0000)
        && ((HS_DRV_EN_O & LS_DRV_EN_O) == 16'h0000))
        else $error("output pin has no driver or both drivers");

    pull_excl_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((PULL_UP_O & PULL_DN_O) == 16'h0000) && ((PULL_UP_O | PULL_DN_O) == PULL_EN_O))
        else $error("pull up and down not exclusive");

endmodule
`default_nettype wire

/* bench/gpcfg_link_bfm.sv */
// link master model: command, write and read strobes on the link clock
`timescale 1ns/1ns
`default_nettype none
module gpcfg_link_bfm (
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rdata_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_o,
    output logic wr_valid_o,
    output logic [7:0] wdata_o,
    output logic rd_req_o
);
    // idle cycles before each request beyond the one that lead always waits, set by the bench for slow hosts
    int gap = 0;
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_o = 8'h00;
        wr_valid_o = 1'b0;
        wdata_o = 8'h00;
        rd_req_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic lead();
        repeat (gap + 1) @(posedge clk_i);
        #1;
    endtask
    // released data lines show the inverse so stale bytes never look valid
    task automatic cmd(input logic [7:0] a);
        lead();
        cmd_o = a;
        cmd_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_o = ~a;
    endtask
    // a request stands until an edge finds the link ready; a hang is left to the watchdog
    task automatic wr(input logic [7:0] d);
        lead();
        wdata_o = d;
        wr_valid_o = 1'b1;
        do
            @(posedge clk_i);
        while (ready_i !== 1'b1);
        #1;
        wr_valid_o = 1'b0;
        wdata_o = ~d;
        do
        begin
            @(posedge clk_i);
            #1;
        end
        while (ready_i !== 1'b1);
    endtask
    task automatic rd(output logic [7:0] d);
        lead();
        rd_req_o = 1'b1;
        do
            @(posedge clk_i);
        while (ready_i !== 1'b1);
        #1;
        rd_req_o = 1'b0;
        do
        begin
            @(posedge clk_i);
            #1;
        end
        while (rd_valid_i !== 1'b1);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* bench/tb_gpcfg_top.sv */
// self-checking bench for the pin configuration and interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_gpcfg_top;
    import gpcfg_pkg::*;
    logic clk, lclk, rst_n, cmd_v, wr_v, rd_r, rdy, rd_v, int_n, int_oe, rd0, rd1;
    logic [7:0] cmd, wd, rdat, got, odb;
    logic [15:0] pin, dir, outv, inval, pen, pup, pdn, hs, ls, m_pe, m_ps, odm;
    logic [31:0] rs = 32'h0000_ea32;
    logic [7:0] rst_tab [11] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    int n_mismatch = 0;
    int n_checks = 0;
    gpcfg_top u_gpcfg_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(lclk), .LINK_CMD_VALID_I(cmd_v),
        .LINK_CMD_I(cmd), .LINK_WR_VALID_I(wr_v), .LINK_WDATA_I(wd), .LINK_RD_REQ_I(rd_r), .LINK_READY_O(rdy),
        .LINK_RDATA_O(rdat), .LINK_RD_VALID_O(rd_v), .PIN_IN_I(pin), .DIR_IN_I(dir), .OUT_VAL_I(outv),
        .IN_RD_P0_I(rd0), .IN_RD_P1_I(rd1), .IN_VALUE_O(inval), .PULL_EN_O(pen), .PULL_UP_O(pup),
        .PULL_DN_O(pdn), .HS_DRV_EN_O(hs), .LS_DRV_EN_O(ls), .INT_N_O(int_n), .INT_OE_O(int_oe));
    gpcfg_link_bfm u_link (.clk_i(lclk), .ready_i(rdy), .rd_valid_i(rd_v), .rdata_i(rdat), .cmd_valid_o(cmd_v),
        .cmd_o(cmd), .wr_valid_o(wr_v), .wdata_o(wd), .rd_req_o(rd_r));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #2;
        forever #3 lclk = ~lclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        u_link.cmd(a);
        u_link.rd(got);
        chk_pin($sformatf("reg %h", a), {8'h00, e}, {8'h00, got});
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        u_link.cmd(a);
        u_link.wr(d);
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdpulse(input logic [1:0] p);
        cw(1);
        {rd1, rd0} = p;
        cw(1);
        {rd1, rd0} = 2'b00;
        cw(3);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_mismatch++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        pin = 16'h0000;
        dir = 16'hffff;
        outv = 16'h0000;
        {rd1, rd0} = 2'b00;
        cw(4);
        rst_n = 1'b1;
        cw(2);
        for (int i = 0; i < 11; i++)
            chk_reg(8'h45 + 8'(i), rst_tab[i]);
        u_link.cmd(8'h4b);
        u_link.wr(8'h5a);
        u_link.wr(8'ha5);
        chk_reg(8'h4a, 8'ha5);
        u_link.rd(got);
        chk_pin("pair", 16'h005a, {8'h00, got});
        wreg(8'h4c, 8'h3c);
        chk_reg(8'h4c, 8'h00);
        // first pass is the corner: every pull on, both ports open-drain
        for (int k = 0; k < 12; k++)
        begin
            rs = xs(rs);
            m_pe = (k == 0) ? 16'hffff : rs[15:0];
            m_ps = rs[31:16];
            rs = xs(rs);
            odb = (k == 0) ? 8'hff : rs[7:0];
            u_link.gap = int'(rs[9:8]);
            wreg(8'h4f, odb);
            cw(1);
            dir = rs[31:16];
            outv = rs[25:10];
            u_link.cmd(8'h46);
            u_link.wr(m_pe[7:0]);
            u_link.wr(m_pe[15:8]);
            u_link.cmd(8'h48);
            u_link.wr(m_ps[7:0]);
            u_link.wr(m_ps[15:8]);
            cw(3);
            odm = {{8{odb[1]}}, {8{odb[0]}}};
            chk_pin("pull_en", m_pe & ~odm, pen);
            chk_pin("pull_up", m_pe & ~odm & m_ps, pup);
            chk_pin("pull_dn", m_pe & ~odm & ~m_ps, pdn);
            chk_pin("hs_drv", ~dir & outv & ~odm, hs);
            chk_pin("ls_drv", ~dir & ~outv, ls);
            chk_reg(8'h4f, {6'h00, odb[1:0]});
            chk_reg(8'h49, m_ps[15:8]);
        end
        cw(1);
        dir = 16'hffff;
        u_link.gap = 0;
        wreg(8'h4f, 8'h00);
        wreg(8'h4a, 8'hff);
        rdpulse(2'b11);
        pin[3] = 1'b1;
        cw(4);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        chk_pin("int_n", 16'h0000, {15'h0000, int_n});
        chk_reg(8'h4c, 8'h00);
        wreg(8'h4a, 8'hf7);
        cw(3);
        chk_pin("irq", 16'h0001, {15'h0000, int_oe});
        chk_reg(8'h4c, 8'h08);
        wreg(8'h4a, 8'hff);
        cw(3);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        wreg(8'h4a, 8'hf7);
        rdpulse(2'b01);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        chk_reg(8'h4c, 8'h00);
        pin[3] = 1'b0;
        cw(4);
        chk_pin("irq", 16'h0001, {15'h0000, int_oe});
        pin[3] = 1'b1;
        cw(4);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        wreg(8'h45, 8'h01);
        wreg(8'h4b, 8'hfe);
        pin[8] = 1'b1;
        cw(4);
        pin[8] = 1'b0;
        cw(4);
        chk_pin("irq", 16'h0001, {15'h0000, int_oe});
        chk_pin("in_value", 16'h0100, inval & 16'h0100);
        chk_reg(8'h4d, 8'h01);
        wreg(8'h4b, 8'hff);
        cw(3);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        wreg(8'h4b, 8'hfe);
        cw(3);
        chk_pin("irq", 16'h0001, {15'h0000, int_oe});
        rdpulse(2'b10);
        chk_pin("irq", 16'h0000, {15'h0000, int_oe});
        chk_pin("in_value", 16'h0008, inval & 16'h0108);
        rst_n = 1'b0;
        cw(2);
        rst_n = 1'b1;
        cw(2);
        chk_reg(8'h4b, 8'hff);
        chk_reg(8'h45, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
